// [verilog/regulator_control_registers.sv]
// Serial-target register bank and enable logic for three linear and four step-down regulators
`timescale 1ns/1ns
`default_nettype none
module regulator_control_registers #(
    parameter logic [6:0] TARGET_ADDR = regulator_pkg::DEFAULT_TARGET_ADDR
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic linearOneEnablePin,
    input wire logic linearTwoEnablePin,
    input wire logic linearThreeEnablePin,
    input wire logic converterOneEnablePin,
    input wire logic converterTwoEnablePin,
    input wire logic converterThreeEnablePin,
    input wire logic converterFourEnablePin,
    input wire logic [2:0] linearBelowQual,
    input wire logic [3:0] converterBelowQual,
    input wire logic standby,
    input wire logic hardReset,
    input wire logic interfaceLogicSupplyLow,
    output logic [2:0] linearOn,
    output logic [3:0] converterOn,
    output regulator_pkg::converter_cfg_s converterCfg [regulator_pkg::NUM_CONV]
);
    logic [7:0] ctl [regulator_pkg::NUM_REGS];
    logic [7:0] next_ctl [regulator_pkg::NUM_REGS];
    regulator_pkg::serial_state_e state, next_state;
    logic [3:0] bitCnt, next_bitCnt;
    logic [7:0] shiftReg, next_shiftReg;
    logic [7:0] ptr, next_ptr;
    logic isRead, next_isRead;
    logic nack, next_nack;
    logic next_sdaOe;
    logic sclPrev, sdaPrev;
    logic sclRise, sclFall, startCond, stopCond;
    logic wrEn;
    logic [7:0] loadByte;
    logic [6:0] keepVec, qualVec, regEnVec, pinVec, belowVec, onVec, next_onVec;
    logic [6:0] offMask, blocked;
    regulator_pkg::converter_cfg_s next_cfg [regulator_pkg::NUM_CONV];

    // Bits each register stores; the rest read as zero
    function automatic logic [7:0] regMask(input int idx);
        if (idx < regulator_pkg::OFS_LDO_TWO_THREE) begin
            return regulator_pkg::MASK_STEP;
        end else if (idx == regulator_pkg::OFS_LDO_TWO_THREE) begin
            return regulator_pkg::MASK_LDO_TWO_THREE;
        end else if (idx == regulator_pkg::OFS_LDO_ONE) begin
            return regulator_pkg::MASK_LDO_ONE;
        end else if (idx < regulator_pkg::NUM_REGS) begin
            return regulator_pkg::MASK_REF;
        end
        return regulator_pkg::READ_NONE;
    endfunction

    // Power-on value of each register
    function automatic logic [7:0] resetValue(input int idx);
        if (idx >= regulator_pkg::OFS_REF_BASE) begin
            return regulator_pkg::RESET_REF;
        end
        return regulator_pkg::RESET_CTL;
    endfunction

    // Pins are synchronous to clk, so one stage of history suffices for edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclIn;
            sdaPrev <= sdaIn;
        end
    end

    assign sclRise = sclIn & ~sclPrev;
    assign sclFall = ~sclIn & sclPrev;
    assign startCond = sclIn & sclPrev & sdaPrev & ~sdaIn;
    assign stopCond = sclIn & sclPrev & ~sdaPrev & sdaIn;
    assign sdaOut = 1'b0; // Open drain: only ever pulls low
    assign loadByte = (int'(ptr) < regulator_pkg::NUM_REGS) ? ctl[ptr[3:0]]
                                                          : regulator_pkg::READ_NONE;

    // Serial target: address, pointer byte, then data bytes with auto-increment
    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_shiftReg = shiftReg;
        next_ptr = ptr;
        next_isRead = isRead;
        next_nack = nack;
        next_sdaOe = sdaOe;
        wrEn = 1'b0;
        if (stopCond || interfaceLogicSupplyLow) begin
            next_state = regulator_pkg::ST_IDLE;
            next_sdaOe = 1'b0;
        end else if (startCond) begin
            next_state = regulator_pkg::ST_ADDR;
            next_bitCnt = 4'h0;
            next_sdaOe = 1'b0;
        end else begin
            case (state)
                regulator_pkg::ST_ADDR, regulator_pkg::ST_PTR, regulator_pkg::ST_WRITE: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaIn};
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == regulator_pkg::BITS_PER_BYTE) begin
                        next_sdaOe = 1'b1;
                        if (state == regulator_pkg::ST_ADDR) begin
                            // A foreign address is ignored until the next start
                            next_isRead = shiftReg[0];
                            next_sdaOe = (shiftReg[7:1] == TARGET_ADDR);
                            next_state = next_sdaOe ? regulator_pkg::ST_ADDR_ACK
                                                    : regulator_pkg::ST_IDLE;
                        end else if (state == regulator_pkg::ST_PTR) begin
                            next_ptr = shiftReg;
                            next_state = regulator_pkg::ST_PTR_ACK;
                        end else begin
                            wrEn = 1'b1;
                            next_ptr = ptr + 8'h1;
                            next_state = regulator_pkg::ST_WRITE_ACK;
                        end
                    end
                end
                regulator_pkg::ST_ADDR_ACK, regulator_pkg::ST_READ_ACK: begin
                    if (sclRise && state == regulator_pkg::ST_READ_ACK) begin
                        next_nack = sdaIn;
                    end else if (sclFall) begin
                        next_bitCnt = 4'h0;
                        next_sdaOe = 1'b0;
                        if (state == regulator_pkg::ST_ADDR_ACK && !isRead) begin
                            next_state = regulator_pkg::ST_PTR;
                        end else if (state == regulator_pkg::ST_READ_ACK && nack) begin
                            next_state = regulator_pkg::ST_IDLE;
                        end else begin
                            next_shiftReg = loadByte;
                            next_sdaOe = ~loadByte[7];
                            next_ptr = ptr + 8'h1;
                            next_state = regulator_pkg::ST_READ;
                        end
                    end
                end
                regulator_pkg::ST_PTR_ACK, regulator_pkg::ST_WRITE_ACK: begin
                    if (sclFall) begin
                        next_bitCnt = 4'h0;
                        next_sdaOe = 1'b0;
                        next_state = regulator_pkg::ST_WRITE;
                    end
                end
                regulator_pkg::ST_READ: begin
                    if (sclRise) begin
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt == regulator_pkg::BITS_PER_BYTE) begin
                            next_sdaOe = 1'b0; // Release for the controller's acknowledge
                            next_state = regulator_pkg::ST_READ_ACK;
                        end else begin
                            next_shiftReg = {shiftReg[6:0], 1'b0};
                            next_sdaOe = ~shiftReg[6];
                        end
                    end
                end
                regulator_pkg::ST_IDLE: begin
                    next_sdaOe = 1'b0;
                end
                default: begin
                    next_state = regulator_pkg::ST_IDLE;
                    next_sdaOe = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= regulator_pkg::ST_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            ptr <= 8'h00;
            isRead <= 1'b0;
            nack <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            shiftReg <= next_shiftReg;
            ptr <= next_ptr;
            isRead <= next_isRead;
            nack <= next_nack;
            sdaOe <= next_sdaOe;
        end
    end
    localparam int TT = regulator_pkg::OFS_LDO_TWO_THREE;
    localparam int LO = regulator_pkg::OFS_LDO_ONE;
    localparam int HI = regulator_pkg::LDO_HI;
    // Register file; supply loss outranks hardware clears, which outrank writes
    always_comb begin
        for (int i = 0; i < regulator_pkg::NUM_REGS; i++) begin
            next_ctl[i] = ctl[i];
        end
        if (wrEn && int'(ptr) < regulator_pkg::NUM_REGS) begin
            next_ctl[ptr[3:0]] = shiftReg & regMask(int'(ptr));
        end
        if (hardReset) begin
            next_ctl[TT][regulator_pkg::LDO_KEEP] = 1'b0;
            next_ctl[TT][regulator_pkg::LDO_KEEP + HI] = 1'b0;
            next_ctl[LO][regulator_pkg::LDO_KEEP] = 1'b0;
            for (int k = 0; k < regulator_pkg::NUM_CONV; k++) begin
                next_ctl[regulator_pkg::OFS_STEP_BASE + k][regulator_pkg::BIT_KEEP] = 1'b0;
            end
        end
        if (interfaceLogicSupplyLow) begin
            for (int i = 0; i < regulator_pkg::NUM_REGS; i++) begin
                next_ctl[i] = resetValue(i);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < regulator_pkg::NUM_REGS; i++) begin
                ctl[i] <= resetValue(i);
            end
        end else begin
            for (int i = 0; i < regulator_pkg::NUM_REGS; i++) begin
                ctl[i] <= next_ctl[i];
            end
        end
    end
    // Gather per-regulator fields: index 0..2 linear one..three, 3..6 converters
    always_comb begin
        keepVec[2:0] = {ctl[TT][regulator_pkg::LDO_KEEP + HI],
                        ctl[TT][regulator_pkg::LDO_KEEP], ctl[LO][regulator_pkg::LDO_KEEP]};
        qualVec[2:0] = {ctl[TT][regulator_pkg::LDO_QUAL + HI],
                        ctl[TT][regulator_pkg::LDO_QUAL], ctl[LO][regulator_pkg::LDO_QUAL]};
        regEnVec[2:0] = {ctl[TT][regulator_pkg::LDO_EN + HI],
                         ctl[TT][regulator_pkg::LDO_EN], ctl[LO][regulator_pkg::LDO_EN]};
        for (int k = 0; k < regulator_pkg::NUM_CONV; k++) begin
            keepVec[3 + k] = ctl[regulator_pkg::OFS_STEP_BASE + k][regulator_pkg::BIT_KEEP];
            qualVec[3 + k] = ctl[regulator_pkg::OFS_STEP_BASE + k][regulator_pkg::BIT_QUAL];
            regEnVec[3 + k] = ctl[regulator_pkg::OFS_STEP_BASE + k][regulator_pkg::BIT_EN];
        end
    end

    assign pinVec = {converterFourEnablePin, converterThreeEnablePin, converterTwoEnablePin,
                     converterOneEnablePin, linearThreeEnablePin, linearTwoEnablePin,
                     linearOneEnablePin};
    assign belowVec = {converterBelowQual, linearBelowQual};
    assign offMask = ~keepVec & ~regEnVec & ~pinVec;
    assign blocked = qualVec & ~belowVec & ~onVec & ~keepVec;
    // Enables; a qualified regulator latches on once it starts, so rising output is no cutoff
    always_comb begin
        for (int i = 0; i < regulator_pkg::NUM_REG_OUT; i++) begin
            next_onVec[i] = keepVec[i]
                | (~standby & (regEnVec[i] | pinVec[i])
                   & (onVec[i] | ~qualVec[i] | belowVec[i]));
        end
    end
    // Converter settings; raw mode 11 falls back to pulse-skipping
    always_comb begin
        for (int k = 0; k < regulator_pkg::NUM_CONV; k++) begin
            next_cfg[k].slewFast = ctl[k][regulator_pkg::BIT_SLEW];
            next_cfg[k].halfFreq = ctl[k][regulator_pkg::BIT_HALF];
            next_cfg[k].phaseTwo = ctl[k][regulator_pkg::BIT_PHASE];
            next_cfg[k].startQual = ctl[k][regulator_pkg::BIT_QUAL];
            if (ctl[k][regulator_pkg::BIT_MODE +: 2] == 2'h3) begin
                next_cfg[k].mode = regulator_pkg::MODE_PULSE_SKIP;
            end else begin
                next_cfg[k].mode = regulator_pkg::mode_e'(
                    ctl[k][regulator_pkg::BIT_MODE +: 2]);
            end
            next_cfg[k].sinkEnable = (next_cfg[k].mode == regulator_pkg::MODE_FORCED);
            next_cfg[k].skipAllowed = (next_cfg[k].mode != regulator_pkg::MODE_FORCED);
            // Analog side turns code into 412.5mV plus 12.5mV per step
            if (ctl[regulator_pkg::OFS_REF_BASE + 2 * k][regulator_pkg::BIT_REF_SEL]) begin
                next_cfg[k].refCode = ctl[regulator_pkg::OFS_REF_BASE + 2 * k + 1][4:0];
            end else begin
                next_cfg[k].refCode = ctl[regulator_pkg::OFS_REF_BASE + 2 * k][4:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            onVec <= 7'h00;
            for (int k = 0; k < regulator_pkg::NUM_CONV; k++) begin
                converterCfg[k] <= regulator_pkg::converter_cfg_s'(13'h0019);
            end
        end else begin
            onVec <= next_onVec;
            for (int k = 0; k < regulator_pkg::NUM_CONV; k++) begin
                converterCfg[k] <= next_cfg[k];
            end
        end
    end

    assign linearOn = onVec[2:0];
    assign converterOn = onVec[6:3];
    logic [7:0] stepOne, refAOne;
    assign stepOne = ctl[regulator_pkg::OFS_STEP_BASE];
    assign refAOne = ctl[regulator_pkg::OFS_REF_BASE];

    chk_keep_forces_on: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> ((onVec & $past(keepVec)) == $past(keepVec)))
        else $error("keep-alive regulator not on");
    chk_pin_low_off: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> ((onVec & $past(offMask)) == 7'h00))
        else $error("regulator on with pin low and enable clear");
    chk_qual_blocks: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> ((onVec & $past(blocked)) == 7'h00))
        else $error("qualified start above threshold");
    chk_standby_off: assert property (@(posedge clk) disable iff (!rstn)
        standby |=> ((onVec & ~$past(keepVec)) == 7'h00))
        else $error("regulator on in standby without keep-alive");
    chk_mode_fallback: assert property (@(posedge clk) disable iff (!rstn)
        (stepOne[6:5] == 2'h3) |=> (converterCfg[0].mode == regulator_pkg::MODE_PULSE_SKIP))
        else $error("mode 11 not pulse-skipping");
    chk_forced_sink: assert property (@(posedge clk) disable iff (!rstn)
        (stepOne[6:5] == 2'h2) |=> converterCfg[0].sinkEnable && !converterCfg[0].skipAllowed)
        else $error("forced mode without sink");
    chk_ref_select: assert property (@(posedge clk) disable iff (!rstn)
        !refAOne[5] |=> (converterCfg[0].refCode == $past(refAOne[4:0])))
        else $error("code A not selected");
    chk_supply_reset: assert property (@(posedge clk) disable iff (!rstn)
        interfaceLogicSupplyLow |=> (refAOne == 8'h19) && (stepOne == 8'h00) ##1
        (converterCfg[0].refCode == 5'h19))
        else $error("supply loss did not restore defaults");
    chk_keep_clear: assert property (@(posedge clk) disable iff (!rstn)
        hardReset |=> !stepOne[1] && !ctl[LO][0])
        else $error("hard reset left keep-alive set");
    chk_slew_freq: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> (converterCfg[0].halfFreq == $past(stepOne[2]))
        && (converterCfg[0].slewFast == $past(stepOne[0])))
        else $error("frequency or slew not following register");
endmodule
`default_nettype wire

// [verilog/regulator_pkg.sv]
// Constants and types for the regulator control register bank
// What this block does
// - Each linear regulator has a standby keep-alive bit, clear lets it turn off.
// - Linear start-up qualification bit: set allows enabling only while output below 300mV.
// - Linear enable bit: clear follows its enable pin, set enables by register.
// - Every control field except the reference codes resets to zero at power-on.
// - Converter bit 0 selects normal or fast switch edge rate.
// - Converter bit 1 set keeps the converter enabled in standby.
// - Converter bit 2 selects 2.25MHz or halved 1.125MHz switching clock.
// - Converter bit 4 set allows start only while output below 300mV.
// - Converter bit 7 enables regardless of pin; clear follows the pin.
// - Forced continuous switches every cycle and may sink; pulse-skipping may omit pulses.
// - Converter reference is 12.5mV times the 5-bit code plus 412.5mV.
// - Every reference code defaults to 11001, giving 725mV.
// - Each converter holds codes A and B; A register bit 5 selects.
// - Interface logic supply below 1V returns all registers to power-on values.
// - Keep-alive forces its regulator on; hard reset or fault clears keep-alive bits.
package regulator_pkg;
    localparam int NUM_REGS = 14;
    localparam int NUM_CONV = 4;
    localparam int NUM_REG_OUT = 7;
    // Register offsets
    localparam int OFS_STEP_BASE = 0;
    localparam int OFS_LDO_TWO_THREE = 4;
    localparam int OFS_LDO_ONE = 5;
    localparam int OFS_REF_BASE = 6;
    // Step-down field positions
    localparam int BIT_SLEW = 0;
    localparam int BIT_KEEP = 1;
    localparam int BIT_HALF = 2;
    localparam int BIT_PHASE = 3;
    localparam int BIT_QUAL = 4;
    localparam int BIT_MODE = 5;
    localparam int BIT_EN = 7;
    // Linear field positions; the second regulator of a register sits LDO_HI above
    localparam int LDO_KEEP = 0;
    localparam int LDO_QUAL = 1;
    localparam int LDO_EN = 2;
    localparam int LDO_HI = 3;
    localparam int BIT_REF_SEL = 5;
    // Writable masks and reset values
    localparam logic [7:0] MASK_STEP = 8'hff;
    localparam logic [7:0] MASK_LDO_TWO_THREE = 8'h3f;
    localparam logic [7:0] MASK_LDO_ONE = 8'h07;
    localparam logic [7:0] MASK_REF = 8'h3f;
    localparam logic [7:0] RESET_CTL = 8'h00;
    localparam logic [7:0] RESET_REF = 8'h19;
    localparam logic [7:0] READ_NONE = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEFAULT_TARGET_ADDR = 7'h3c;

    typedef enum logic [1:0] {
        MODE_PULSE_SKIP = 2'h0,
        MODE_BURST = 2'h1,
        MODE_FORCED = 2'h2
    } mode_e;

    typedef struct packed {
        logic slewFast;
        logic halfFreq;
        logic phaseTwo;
        logic startQual;
        mode_e mode;
        logic sinkEnable;
        logic skipAllowed;
        logic [4:0] refCode;
    } converter_cfg_s;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WRITE = 9'h020,
        ST_WRITE_ACK = 9'h040,
        ST_READ = 9'h080,
        ST_READ_ACK = 9'h100
    } serial_state_e;
endpackage

// [bench/serial_host_model.sv]
// Serial bus controller model that writes and reads device registers
`timescale 1ns/1ns
`default_nettype none
module serial_host_model #(
    parameter logic [6:0] ADDR = regulator_pkg::DEFAULT_TARGET_ADDR
) (
    input wire logic clk,
    input wire logic sdaWire,
    output logic scl,
    output logic sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // One bus phase is four clocks; scl and sda never move on the same edge
    task automatic step(input logic c, input logic low);
        @(posedge clk);
        scl <= c;
        sdaLow <= low;
        repeat (3) @(posedge clk);
    endtask
    task automatic bitx(input logic b, output logic got);
        step(1'b0, sdaLow);
        step(1'b0, !b);
        step(1'b1, !b);
        got = sdaWire;
    endtask
    // Sending a one releases the wire, so reads pass 8'hff
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic nack);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(last, nack);
    endtask
    task automatic start();
        step(1'b0, sdaLow);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, sdaLow);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic writeReg(input logic [7:0] p, input logic [7:0] d, output logic nack);
        logic [7:0] r;
        logic n0, n1, n2;
        start();
        xfer({ADDR, 1'b0}, 1'b1, r, n0);
        xfer(p, 1'b1, r, n1);
        xfer(d, 1'b1, r, n2);
        stop();
        nack = n0 | n1 | n2;
    endtask
    task automatic readReg(input logic [7:0] p, output logic [7:0] d, output logic nack);
        logic [7:0] r;
        logic n0, n1, n2, n3;
        start();
        xfer({ADDR, 1'b0}, 1'b1, r, n0);
        xfer(p, 1'b1, r, n1);
        start();
        xfer({ADDR, 1'b1}, 1'b1, r, n2);
        xfer(8'hff, 1'b1, d, n3);
        stop();
        nack = n0 | n1 | n2;
    endtask
endmodule
`default_nettype wire

// [bench/regulator_control_registers_tb.sv]
// Self-checking bench for the regulator control register bank
`timescale 1ns/1ns
`default_nettype none
module regulator_control_registers_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic scl, hostLow, sdaOe, sdaOut;
    logic [6:0] pins = '0;
    logic [2:0] linBelow = '0;
    logic [3:0] convBelow = '0;
    logic standby = 1'b0;
    logic hardReset = 1'b0;
    logic supplyLow = 1'b0;
    logic [2:0] linearOn;
    logic [3:0] converterOn;
    regulator_pkg::converter_cfg_s converterCfg [regulator_pkg::NUM_CONV];
    logic [7:0] regVal [15];
    logic [6:0] expOn = '0;
    logic [31:0] expQ [$];
    logic [31:0] resData = '0;
    logic [31:0] noted;
    logic resValid = 1'b0;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    wire logic sdaWire;
    // Open-drain wire with pull-up
    assign sdaWire = !(hostLow | sdaOe);
    initial forever #10 clk = ~clk;
    serial_host_model u_host (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(hostLow));
    regulator_control_registers u_dut (.clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .linearOneEnablePin(pins[0]),
        .linearTwoEnablePin(pins[1]), .linearThreeEnablePin(pins[2]),
        .converterOneEnablePin(pins[3]), .converterTwoEnablePin(pins[4]),
        .converterThreeEnablePin(pins[5]), .converterFourEnablePin(pins[6]),
        .linearBelowQual(linBelow), .converterBelowQual(convBelow), .standby(standby),
        .hardReset(hardReset), .interfaceLogicSupplyLow(supplyLow), .linearOn(linearOn),
        .converterOn(converterOn), .converterCfg(converterCfg));
    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, well above the expected length of the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            give_verdict();
        end
    end
    // Watcher takes the oldest note whenever a result is shown
    always @(posedge clk) begin
        if (resValid) begin
            noted = expQ.pop_front();
            tests_run++;
            if (noted !== resData) begin
                miscompares++;
                $display("wrong value at %0t: expected %h got %h", $time, noted, resData);
            end
        end
    end
    // The idle cycle keeps resValid from being assigned twice in one step
    task automatic check(input logic [31:0] e, input logic [31:0] g);
        expQ.push_back(e);
        resData <= g;
        resValid <= 1'b1;
        @(posedge clk);
        resValid <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] maskOf(int i);
        return i < 4 ? regulator_pkg::MASK_STEP : i == 4 ? regulator_pkg::MASK_LDO_TWO_THREE :
            i == 5 ? regulator_pkg::MASK_LDO_ONE : i < 14 ? regulator_pkg::MASK_REF : 8'h00;
    endfunction
    function automatic logic [7:0] rstVal(int i);
        return (i > 5 && i < 14) ? regulator_pkg::RESET_REF : regulator_pkg::RESET_CTL;
    endfunction
    // Bits 0..2 linear one..three, 3..6 converters; f is {enable, qualify, keep}
    function automatic logic [6:0] onOf();
        logic [6:0] r;
        logic [2:0] f;
        logic below;
        for (int k = 0; k < 7; k++) begin
            f = k == 0 ? regVal[5][2:0] : k == 1 ? regVal[4][2:0] : k == 2 ? regVal[4][5:3] :
                {regVal[k-3][7], regVal[k-3][4], regVal[k-3][1]};
            below = k < 3 ? linBelow[k] : convBelow[k-3];
            r[k] = f[0] | (!standby & (f[2] | pins[k]) & (expOn[k] | !f[1] | below));
        end
        return r;
    endfunction
    task automatic readAll();
        logic [7:0] d;
        logic n;
        for (int i = 0; i < 15; i++) begin
            u_host.readReg(8'(i), d, n);
            check(regVal[i], d);
            check(0, n);
        end
    endtask
    task automatic cfgAll();
        logic [7:0] v;
        regulator_pkg::converter_cfg_s s;
        for (int c = 0; c < 4; c++) begin
            v = regVal[c];
            s.slewFast = v[0];
            s.halfFreq = v[2];
            s.phaseTwo = v[3];
            s.startQual = v[4];
            s.mode = v[6:5] == 2'h3 ? regulator_pkg::MODE_PULSE_SKIP
                                    : regulator_pkg::mode_e'(v[6:5]);
            s.sinkEnable = s.mode == regulator_pkg::MODE_FORCED;
            // Only forced continuous switches every cycle; the other modes may skip
            s.skipAllowed = s.mode != regulator_pkg::MODE_FORCED;
            s.refCode = regVal[6+2*c][5] ? regVal[7+2*c][4:0] : regVal[6+2*c][4:0];
            check(32'(s), 32'(converterCfg[c]));
        end
    endtask
    initial begin
        logic [7:0] d;
        logic n;
        d = 8'($urandom(57));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 15; i++) regVal[i] = rstVal(i);
        readAll();
        cfgAll();
        repeat (2) begin
            // Standby during writes so the on state carries no history
            standby <= 1'b1;
            for (int i = 0; i < 15; i++) begin
                d = 8'($urandom);
                u_host.writeReg(8'(i), d, n);
                check(0, n);
                regVal[i] = d & maskOf(i);
            end
            readAll();
            cfgAll();
            expOn = onOf();
            repeat (60) begin
                {pins, linBelow, convBelow, standby} <= 15'($urandom);
                repeat (4) @(posedge clk);
                expOn = onOf();
                check(expOn, {converterOn, linearOn});
            end
        end
        // Forced mode and the spare code 11 are rare in random data, so set each once
        for (int m = 2; m < 4; m++) begin
            u_host.writeReg(8'h00, 8'(m << 5), n);
            check(0, {sdaOut, n});
            regVal[0] = 8'(m << 5);
            cfgAll();
        end
        hardReset <= 1'b1;
        @(posedge clk);
        hardReset <= 1'b0;
        regVal[4] &= 8'hf6;
        regVal[5] &= 8'hfe;
        for (int c = 0; c < 4; c++) regVal[c] &= 8'hfd;
        readAll();
        supplyLow <= 1'b1;
        @(posedge clk);
        supplyLow <= 1'b0;
        for (int i = 0; i < 15; i++) regVal[i] = rstVal(i);
        readAll();
        cfgAll();
        give_verdict();
    end
endmodule
`default_nettype wire
